// file: core/apgc_pkg.sv
// Package of constants, types and helpers for the front-end power and gain control
package apgc_pkg;

   // Channel count and field widths
   localparam int unsigned CHANNELS      = 2;
   localparam int unsigned GAIN_CODE_W   = 3;
   localparam int unsigned GAIN_VAL_W    = 6;
   localparam int unsigned QUANT_COMPS   = 4;
   localparam int unsigned QUANT_LEVEL_W = 3;
   localparam int unsigned DATA_W        = 24;

   // Control code that requests every converter down
   localparam logic [1:0] ALL_CHANNELS_DOWN = 2'h3;

   // Gain codes and their gain in volts per volt
   localparam logic [2:0] GAIN_CODE_X1  = 3'h0;
   localparam logic [2:0] GAIN_CODE_X2  = 3'h1;
   localparam logic [2:0] GAIN_CODE_X4  = 3'h2;
   localparam logic [2:0] GAIN_CODE_X8  = 3'h3;
   localparam logic [2:0] GAIN_CODE_X16 = 3'h4;
   localparam logic [2:0] GAIN_CODE_X32 = 3'h5;
   localparam logic [5:0] GAIN_VAL_X1   = 6'h01;
   localparam logic [5:0] GAIN_VAL_X2   = 6'h02;
   localparam logic [5:0] GAIN_VAL_X4   = 6'h04;
   localparam logic [5:0] GAIN_VAL_X8   = 6'h08;
   localparam logic [5:0] GAIN_VAL_X16  = 6'h10;
   localparam logic [5:0] GAIN_VAL_X32  = 6'h20;

   // Modulator timing: master 4 MHz divided to a 1 MHz sample clock
   localparam longint unsigned SYS_CLK_HZ     = 200_000_000;
   localparam longint unsigned MASTER_CLK_HZ  = 4_000_000;
   localparam longint unsigned MOD_SAMPLE_HZ  = 1_000_000;
   localparam int unsigned     MASTER_DIV     = int'(MASTER_CLK_HZ / MOD_SAMPLE_HZ);
   localparam int unsigned     SAMPLE_CYCLES  = int'(SYS_CLK_HZ / MOD_SAMPLE_HZ);
   localparam int unsigned     SAMPLE_CNT_W   = $clog2(SAMPLE_CYCLES);
   localparam logic [SAMPLE_CNT_W-1:0] SAMPLE_LAST = SAMPLE_CNT_W'(SAMPLE_CYCLES - 1);
   localparam logic [SAMPLE_CNT_W-1:0] SAMPLE_HALF = SAMPLE_CNT_W'(SAMPLE_CYCLES / 2);

   // Reset values
   localparam logic [SAMPLE_CNT_W-1:0] SAMPLE_CNT_RST = '0;
   localparam logic [DATA_W-1:0]       DATA_RST       = 24'h000000;

   // Power state, one-hot
   typedef enum logic [2:0] {
      PWR_RUN  = 3'h1,   // At least one converter running
      PWR_IDLE = 3'h2,   // Both converters down, clocks gated
      PWR_FULL = 3'h4    // Full power-down
   } apgc_pwr_t;

   // Number of tripped comparators, the quantizer level 0..4
   function automatic logic [2:0] apgc_ones(input logic [3:0] v);
      logic [2:0] n;
      n = 3'h0;
      for (int i = 0; i < 4; i++) begin
         n = n + {2'h0, v[i]};
      end
      return n;
   endfunction : apgc_ones

   // Thermometer word for a quantizer level
   function automatic logic [3:0] apgc_therm(input logic [2:0] lvl);
      logic [3:0] t;
      t = 4'h0;
      for (int i = 0; i < 4; i++) begin
         t[i] = (3'(i) < lvl);
      end
      return t;
   endfunction : apgc_therm

endpackage : apgc_pkg

// file: core/apgc_gain_decode.sv
// Registered decoder from a channel gain code to its gain value
`timescale 1ns/100ps
module apgc_gain_decode
   import apgc_pkg::*;
(
   // Clock and reset
   input  wire logic                   clock_i,
   input  wire logic                   rst_n_i,
   // Gain code in, gain out
   input  wire logic [GAIN_CODE_W-1:0] channel_gain_code_i,
   output logic      [GAIN_VAL_W-1:0]  gain_o
);

   logic [GAIN_VAL_W-1:0] gain_r;    // Decoded gain
   logic [GAIN_VAL_W-1:0] gain_nxt;  // Next decoded gain

   // Table lookup
   always_comb begin
      unique case (channel_gain_code_i)
         GAIN_CODE_X1:  gain_nxt = GAIN_VAL_X1;
         GAIN_CODE_X2:  gain_nxt = GAIN_VAL_X2;
         GAIN_CODE_X4:  gain_nxt = GAIN_VAL_X4;
         GAIN_CODE_X8:  gain_nxt = GAIN_VAL_X8;
         GAIN_CODE_X16: gain_nxt = GAIN_VAL_X16;
         GAIN_CODE_X32: gain_nxt = GAIN_VAL_X32;
         // The two spare codes fall back to unity gain
         default:       gain_nxt = GAIN_VAL_X1;
      endcase
   end

   // Register the result
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gain_r <= GAIN_VAL_X1;
      end else begin
         gain_r <= gain_nxt;
      end
   end

   assign gain_o = gain_r;

endmodule : apgc_gain_decode

// file: core/apgc_sample_div.sv
// Divider producing the modulator sample clock and its update tick
`timescale 1ns/100ps
module apgc_sample_div
   import apgc_pkg::*;
(
   // Clock and reset
   input  wire logic clock_i,
   input  wire logic rst_n_i,
   // Gate: counter clears to zero while the clock is not distributed
   input  wire logic enable_i,
   // Outputs
   output logic      sample_clk_o,
   output logic      update_o
);

   logic [SAMPLE_CNT_W-1:0] cnt_r;    // Cycle counter
   logic [SAMPLE_CNT_W-1:0] cnt_nxt;
   logic                    clk_r;    // Divided clock level
   logic                    clk_nxt;
   logic                    upd_r;    // One-cycle update tick
   logic                    upd_nxt;

   // Count one sample period; a gated divider restarts from zero
   always_comb begin
      cnt_nxt = SAMPLE_CNT_RST;
      clk_nxt = 1'b0;
      upd_nxt = 1'b0;
      if (enable_i) begin
         if (cnt_r == SAMPLE_LAST) begin
            upd_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r + SAMPLE_CNT_W'(1);
         end
         clk_nxt = (cnt_r < SAMPLE_HALF);
      end
   end

   // Register state
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_r <= SAMPLE_CNT_RST;
         clk_r <= 1'b0;
         upd_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         clk_r <= clk_nxt;
         upd_r <= upd_nxt;
      end
   end

   assign sample_clk_o = clk_r;
   assign update_o     = upd_r;

endmodule : apgc_sample_div

// file: core/apgc_top.sv
// Power-down, gain and modulator control of a two-channel front end
//
// Contract
// - Full power-down needs both down bits, both selects
// - Full power-down: analog, monitors, clocks off
// - Full power-down: channels down, internal reference off
// - Full power-down only in SPI mode
// - Serial interface stays alive in full power-down
// - Full power-down stops input sampling clock
// - Any control bit cleared re-enables monitors
// - Each channel has its own gain code
// - Gain codes 0..5 map 1 to 32
// - Spare gain codes mean unity gain
// - Four comparators give thermometer-coded five levels
// - Modulator updates once per sample clock period
// - Each channel powers down on its own
// - Powered-down channel: zero data, no ready
`timescale 1ns/100ps
module apgc_top
   import apgc_pkg::*;
(
   // Clock and reset
   input  wire logic                   clock_i,
   input  wire logic                   rst_n_i,
   // Interface mode pin, high in SPI mode
   input  wire logic                   spi_mode_i,
   // Control bits written through the serial interface
   input  wire logic [CHANNELS-1:0]    channel_power_down_i,
   input  wire logic                   external_reference_select_i,
   input  wire logic                   external_clock_select_i,
   input  wire logic [GAIN_CODE_W-1:0] channel_gain_code_ch0_i,
   input  wire logic [GAIN_CODE_W-1:0] channel_gain_code_ch1_i,
   // Raw comparator outputs from the analog quantizers
   input  wire logic [QUANT_COMPS-1:0] comparator_ch0_i,
   input  wire logic [QUANT_COMPS-1:0] comparator_ch1_i,
   // Conversion results from the filters
   input  wire logic [DATA_W-1:0]      conv_data_ch0_i,
   input  wire logic [DATA_W-1:0]      conv_data_ch1_i,
   input  wire logic [CHANNELS-1:0]    conv_ready_i,
   // Power status and enables
   output logic                        full_power_down_o,
   output logic                        analog_enable_o,
   output logic                        por_monitor_enable_o,
   output logic                        internal_reference_enable_o,
   output logic                        clock_distribution_enable_o,
   output logic                        input_sampling_clock_enable_o,
   output logic                        serial_interface_enable_o,
   output logic [CHANNELS-1:0]         channel_enable_o,
   // Decoded gains
   output logic [GAIN_VAL_W-1:0]       gain_ch0_o,
   output logic [GAIN_VAL_W-1:0]       gain_ch1_o,
   // Modulator timing and quantizer results
   output logic                        modulator_sample_clock_o,
   output logic                        modulator_update_o,
   output logic [QUANT_COMPS-1:0]      quant_therm_ch0_o,
   output logic [QUANT_COMPS-1:0]      quant_therm_ch1_o,
   output logic [QUANT_LEVEL_W-1:0]    quant_level_ch0_o,
   output logic [QUANT_LEVEL_W-1:0]    quant_level_ch1_o,
   // Gated channel data
   output logic [DATA_W-1:0]           data_ch0_o,
   output logic [DATA_W-1:0]           data_ch1_o,
   output logic [CHANNELS-1:0]         data_ready_o
);

   // Pin synchronisers; the first stage is read only by the second
   logic                   spi_mode_s1_r;
   logic                   spi_mode_s2_r;
   logic [QUANT_COMPS-1:0] comp0_s1_r;
   logic [QUANT_COMPS-1:0] comp0_s2_r;
   logic [QUANT_COMPS-1:0] comp1_s1_r;
   logic [QUANT_COMPS-1:0] comp1_s2_r;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         spi_mode_s1_r <= 1'b0;
         spi_mode_s2_r <= 1'b0;
         comp0_s1_r    <= 4'h0;
         comp0_s2_r    <= 4'h0;
         comp1_s1_r    <= 4'h0;
         comp1_s2_r    <= 4'h0;
      end else begin
         spi_mode_s1_r <= spi_mode_i;
         spi_mode_s2_r <= spi_mode_s1_r;
         comp0_s1_r    <= comparator_ch0_i;
         comp0_s2_r    <= comp0_s1_r;
         comp1_s1_r    <= comparator_ch1_i;
         comp1_s2_r    <= comp1_s1_r;
      end
   end

   // Power state machine
   apgc_pwr_t pwr_r;          // Current power state
   apgc_pwr_t pwr_nxt;        // Next power state
   logic      full_req;       // Full power-down condition
   logic      both_down;      // Both converters down

   // Decide the power state straight from the control bits
   always_comb begin
      both_down = (channel_power_down_i == ALL_CHANNELS_DOWN);
      // Two-wire mode never qualifies, whatever the bits say
      full_req  = both_down && external_reference_select_i && external_clock_select_i
                  && spi_mode_s2_r;
      pwr_nxt   = PWR_RUN;
      unique case (pwr_r)
         PWR_RUN, PWR_IDLE, PWR_FULL: begin
            // Clearing any one bit leaves full power-down at once
            if (full_req) begin
               pwr_nxt = PWR_FULL;
            end else if (both_down) begin
               pwr_nxt = PWR_IDLE;
            end else begin
               pwr_nxt = PWR_RUN;
            end
         end
         // Illegal code recovers to running
         default: pwr_nxt = PWR_RUN;
      endcase
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pwr_r <= PWR_RUN;
      end else begin
         pwr_r <= pwr_nxt;
      end
   end

   // Power enables derived from the next state so they track it exactly
   logic                full_r;
   logic                full_nxt;
   logic                analog_en_r;
   logic                analog_en_nxt;
   logic                por_en_r;
   logic                por_en_nxt;
   logic                iref_en_r;
   logic                iref_en_nxt;
   logic                clk_dist_r;
   logic                clk_dist_nxt;
   logic                in_clk_r;
   logic                in_clk_nxt;
   logic [CHANNELS-1:0] ch_en_r;
   logic [CHANNELS-1:0] ch_en_nxt;

   always_comb begin
      full_nxt      = (pwr_nxt == PWR_FULL);
      analog_en_nxt = !full_nxt;
      por_en_nxt    = !full_nxt;
      // Internal reference only runs when selected and not fully down
      iref_en_nxt   = !full_nxt && !external_reference_select_i;
      // No clock anywhere once every converter is down
      clk_dist_nxt  = (pwr_nxt == PWR_RUN);
      in_clk_nxt    = (pwr_nxt == PWR_RUN);
      // Bit n drives channel n; full power-down forces both channels off
      ch_en_nxt     = full_nxt ? '0 : ~channel_power_down_i;
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         full_r      <= 1'b0;
         analog_en_r <= 1'b1;
         por_en_r    <= 1'b1;
         iref_en_r   <= 1'b1;
         clk_dist_r  <= 1'b1;
         in_clk_r    <= 1'b1;
         ch_en_r     <= '1;
      end else begin
         full_r      <= full_nxt;
         analog_en_r <= analog_en_nxt;
         por_en_r    <= por_en_nxt;
         iref_en_r   <= iref_en_nxt;
         clk_dist_r  <= clk_dist_nxt;
         in_clk_r    <= in_clk_nxt;
         ch_en_r     <= ch_en_nxt;
      end
   end

   // Gain decoders, one per channel code
   apgc_gain_decode u_gain0 (
      .clock_i             (clock_i),
      .rst_n_i             (rst_n_i),
      .channel_gain_code_i (channel_gain_code_ch0_i),
      .gain_o              (gain_ch0_o)
   );

   apgc_gain_decode u_gain1 (
      .clock_i             (clock_i),
      .rst_n_i             (rst_n_i),
      .channel_gain_code_i (channel_gain_code_ch1_i),
      .gain_o              (gain_ch1_o)
   );

   // Modulator sample clock; stops with clock distribution
   logic upd_tick;  // One update per sample period

   apgc_sample_div u_div (
      .clock_i      (clock_i),
      .rst_n_i      (rst_n_i),
      .enable_i     (clk_dist_r),
      .sample_clk_o (modulator_sample_clock_o),
      .update_o     (upd_tick)
   );

   // Quantizer capture, refreshed only on the update tick
   logic [QUANT_LEVEL_W-1:0] lvl0_r;
   logic [QUANT_LEVEL_W-1:0] lvl0_nxt;
   logic [QUANT_LEVEL_W-1:0] lvl1_r;
   logic [QUANT_LEVEL_W-1:0] lvl1_nxt;
   logic [QUANT_COMPS-1:0]   th0_r;
   logic [QUANT_COMPS-1:0]   th0_nxt;
   logic [QUANT_COMPS-1:0]   th1_r;
   logic [QUANT_COMPS-1:0]   th1_nxt;
   logic                     upd_r;
   logic                     upd_nxt;

   // Count tripped comparators then rebuild a clean thermometer,
   // so a bubble from a slow comparator cannot leave a broken code
   always_comb begin
      lvl0_nxt = lvl0_r;
      lvl1_nxt = lvl1_r;
      upd_nxt  = upd_tick;
      if (upd_tick) begin
         lvl0_nxt = ch_en_r[0] ? apgc_ones(comp0_s2_r) : 3'h0;
         lvl1_nxt = ch_en_r[1] ? apgc_ones(comp1_s2_r) : 3'h0;
      end
      th0_nxt = apgc_therm(lvl0_nxt);
      th1_nxt = apgc_therm(lvl1_nxt);
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lvl0_r <= 3'h0;
         lvl1_r <= 3'h0;
         th0_r  <= 4'h0;
         th1_r  <= 4'h0;
         upd_r  <= 1'b0;
      end else begin
         lvl0_r <= lvl0_nxt;
         lvl1_r <= lvl1_nxt;
         th0_r  <= th0_nxt;
         th1_r  <= th1_nxt;
         upd_r  <= upd_nxt;
      end
   end

   // Channel data gating
   logic [DATA_W-1:0]   d0_r;
   logic [DATA_W-1:0]   d0_nxt;
   logic [DATA_W-1:0]   d1_r;
   logic [DATA_W-1:0]   d1_nxt;
   logic [CHANNELS-1:0] rdy_r;
   logic [CHANNELS-1:0] rdy_nxt;

   // A powered-down channel shows zeros and never flags ready
   always_comb begin
      d0_nxt  = ch_en_r[0] ? conv_data_ch0_i : DATA_RST;
      d1_nxt  = ch_en_r[1] ? conv_data_ch1_i : DATA_RST;
      rdy_nxt = conv_ready_i & ch_en_r;
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         d0_r  <= DATA_RST;
         d1_r  <= DATA_RST;
         rdy_r <= '0;
      end else begin
         d0_r  <= d0_nxt;
         d1_r  <= d1_nxt;
         rdy_r <= rdy_nxt;
      end
   end

   // Output wiring, all from flip-flops except the serial enable, which is tied high
   assign full_power_down_o             = full_r;
   assign analog_enable_o               = analog_en_r;
   assign por_monitor_enable_o          = por_en_r;
   assign internal_reference_enable_o   = iref_en_r;
   assign clock_distribution_enable_o   = clk_dist_r;
   assign input_sampling_clock_enable_o = in_clk_r;
   // Serial logic is never gated; the host must still reach the bits
   assign serial_interface_enable_o     = spi_mode_s2_r | ~spi_mode_s2_r;
   assign channel_enable_o              = ch_en_r;
   assign modulator_update_o            = upd_r;
   assign quant_therm_ch0_o             = th0_r;
   assign quant_therm_ch1_o             = th1_r;
   assign quant_level_ch0_o             = lvl0_r;
   assign quant_level_ch1_o             = lvl1_r;
   assign data_ch0_o                    = d0_r;
   assign data_ch1_o                    = d1_r;
   assign data_ready_o                  = rdy_r;

endmodule : apgc_top

// file: bench/apgc_chk.sv
// Checker of power-down, gain, data gating and modulator timing at the top ports
`timescale 1ns/100ps
module apgc_chk
   import apgc_pkg::*;
(
   // Clock and reset
   input wire logic                   clock_i,
   input wire logic                   rst_n_i,
   // Control inputs
   input wire logic                   spi_mode_i,
   input wire logic [CHANNELS-1:0]    channel_power_down_i,
   input wire logic                   external_reference_select_i,
   input wire logic                   external_clock_select_i,
   input wire logic [GAIN_CODE_W-1:0] channel_gain_code_ch0_i,
   input wire logic [GAIN_CODE_W-1:0] channel_gain_code_ch1_i,
   // Watched outputs
   input wire logic                   full_power_down_o,
   input wire logic                   analog_enable_o,
   input wire logic                   por_monitor_enable_o,
   input wire logic                   internal_reference_enable_o,
   input wire logic                   clock_distribution_enable_o,
   input wire logic                   input_sampling_clock_enable_o,
   input wire logic                   serial_interface_enable_o,
   input wire logic [CHANNELS-1:0]    channel_enable_o,
   input wire logic [GAIN_VAL_W-1:0]  gain_ch0_o,
   input wire logic [GAIN_VAL_W-1:0]  gain_ch1_o,
   input wire logic                   modulator_update_o,
   input wire logic [QUANT_COMPS-1:0] quant_therm_ch0_o,
   input wire logic [QUANT_LEVEL_W-1:0] quant_level_ch0_o,
   input wire logic [DATA_W-1:0]      data_ch0_o,
   input wire logic [CHANNELS-1:0]    data_ready_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   // Own gain table, spare codes fall back to unity
   function automatic logic [5:0] gx(input logic [2:0] c);
      return (c < 3'h6) ? (6'h01 << c) : 6'h01;
   endfunction : gx

   // Cycles since the last update; only trusted once an update was seen
   logic [7:0] gap_r, gap_nxt;
   logic       seen_r, seen_nxt;
   always_comb begin
      gap_nxt  = (modulator_update_o || !clock_distribution_enable_o) ? 8'h00 : gap_r + 8'h01;
      seen_nxt = clock_distribution_enable_o && (seen_r || modulator_update_o);
   end
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gap_r  <= 8'h00;
         seen_r <= 1'b0;
      end else begin
         gap_r  <= gap_nxt;
         seen_r <= seen_nxt;
      end
   end

   // Mode pin held through its synchroniser, then the down request
   sequence s_full_req;
      spi_mode_i[*3] ##0 (channel_power_down_i == 2'h3 && external_reference_select_i && external_clock_select_i);
   endsequence
   sequence s_full_left;
      full_power_down_o && (channel_power_down_i != 2'h3 || !external_reference_select_i || !external_clock_select_i);
   endsequence

   property p_full_entry; s_full_req |=> full_power_down_o; endproperty
   property p_full_exit; s_full_left |=> !full_power_down_o && por_monitor_enable_o; endproperty
   property p_full_off;
      full_power_down_o |-> !analog_enable_o && !por_monitor_enable_o && !clock_distribution_enable_o
         && !internal_reference_enable_o && channel_enable_o == 2'h0;
   endproperty
   property p_sampling; full_power_down_o |-> !input_sampling_clock_enable_o; endproperty
   property p_serial; full_power_down_o |-> serial_interface_enable_o; endproperty
   property p_two_wire; (!spi_mode_i)[*4] |=> !full_power_down_o; endproperty
   property p_gain;
      $past(rst_n_i) |-> gain_ch0_o == gx($past(channel_gain_code_ch0_i))
         && gain_ch1_o == gx($past(channel_gain_code_ch1_i));
   endproperty
   property p_data_gate; !channel_enable_o[0] |=> data_ch0_o == 24'h000000 && !data_ready_o[0]; endproperty
   property p_chan_map; channel_power_down_i == 2'h1 |=> channel_enable_o == 2'h2; endproperty
   property p_update; seen_r && gap_r == 8'hC7 |-> modulator_update_o; endproperty
   property p_therm;
      quant_level_ch0_o <= 3'h4 && quant_therm_ch0_o == (4'h1 << quant_level_ch0_o) - 4'h1;
   endproperty

   a_full_entry:
      assert property (p_full_entry) else $error("full power-down not entered");
   a_full_exit:
      assert property (p_full_exit) else $error("monitors not back after exit");
   a_full_off:
      assert property (p_full_off) else $error("circuitry still on in full power-down");
   a_sampling:
      assert property (p_sampling) else $error("input sampling clock running");
   a_serial:
      assert property (p_serial) else $error("serial logic gated");
   a_two_wire:
      assert property (p_two_wire) else $error("full power-down in two-wire mode");
   a_gain:
      assert property (p_gain) else $error("gain decode wrong");
   a_data_gate:
      assert property (p_data_gate) else $error("down channel shows data");
   a_chan_map:
      assert property (p_chan_map) else $error("down bit maps to wrong channel");
   a_update:
      assert property (p_update) else $error("update period not 200 cycles");
   a_therm:
      assert property (p_therm) else $error("quantizer word not thermometer");
endmodule : apgc_chk

bind apgc_top apgc_chk i_apgc_chk (.*);

// file: bench/apgc_host_model.sv
// Host model holding the control bits written over the serial link
`timescale 1ns/100ps
module apgc_host_model (
   // Clock
   input  wire logic clock_i,
   // Control bits towards the block
   output logic       spi_mode_o,
   output logic [1:0] power_down_o,
   output logic       ext_ref_o,
   output logic       ext_clk_o,
   output logic [2:0] gain0_o,
   output logic [2:0] gain1_o
);
   // Power-up settings: SPI mode, everything running
   initial begin
      {spi_mode_o, power_down_o, ext_ref_o, ext_clk_o, gain0_o, gain1_o} = {1'b1, 2'h0, 1'b0, 1'b0, 6'h00};
   end

   // One write lands just after a falling edge, all bits together
   task automatic host_write(input logic s, input logic [1:0] p, input logic r, input logic k,
                             input logic [2:0] g0, input logic [2:0] g1);
      @(negedge clock_i);
      {spi_mode_o, power_down_o, ext_ref_o, ext_clk_o, gain0_o, gain1_o} = {s, p, r, k, g0, g1};
   endtask : host_write
endmodule : apgc_host_model

// file: bench/test_afe_power_gain_control.sv
// Self-checking bench for the power-down, gain and modulator control
`timescale 1ns/100ps
module test_afe_power_gain_control;
   import apgc_pkg::*;
   // Stimulus and observed ports, named as the design ports
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic spi_mode_i, external_reference_select_i, external_clock_select_i;
   logic [1:0] channel_power_down_i, channel_enable_o, data_ready_o;
   logic [1:0] conv_ready_i = 2'h0;
   logic [2:0] channel_gain_code_ch0_i, channel_gain_code_ch1_i, quant_level_ch0_o, quant_level_ch1_o;
   logic [3:0] comparator_ch0_i = 4'h5;
   logic [3:0] comparator_ch1_i = 4'hF;
   logic [3:0] quant_therm_ch0_o, quant_therm_ch1_o;
   logic [23:0] conv_data_ch0_i = 24'h000000;
   logic [23:0] conv_data_ch1_i = 24'h000000;
   logic [23:0] data_ch0_o, data_ch1_o;
   logic [5:0] gain_ch0_o, gain_ch1_o;
   logic full_power_down_o, analog_enable_o, por_monitor_enable_o, internal_reference_enable_o;
   logic clock_distribution_enable_o, input_sampling_clock_enable_o, serial_interface_enable_o;
   logic modulator_sample_clock_o, modulator_update_o;
   int fail_count = 0;
   int checks = 0;

   // 200 MHz clock
   always #2.5 clock_i = ~clock_i;

   apgc_top i_apgc_top (.*);
   apgc_host_model i_apgc_host_model (
      .clock_i      (clock_i),
      .spi_mode_o   (spi_mode_i),
      .power_down_o (channel_power_down_i),
      .ext_ref_o    (external_reference_select_i),
      .ext_clk_o    (external_clock_select_i),
      .gain0_o      (channel_gain_code_ch0_i),
      .gain1_o      (channel_gain_code_ch1_i)
   );

   // Verdict and end of run
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : finish_test

   // Compare one value, report at once
   task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(negedge clock_i);
   endtask : cyc

   // Gain expected from the code, spare codes give unity
   function automatic logic [5:0] gx(input logic [2:0] c);
      return (c < 3'h6) ? (6'h01 << c) : 6'h01;
   endfunction : gx

   // Bounded wait for the next update pulse; n counts falling edges
   task automatic wait_update(output int n);
      n = 0;
      do begin
         @(negedge clock_i);
         n++;
      end while (modulator_update_o !== 1'b1 && n < 500);
      if (modulator_update_o !== 1'b1) begin
         fail_count++;
         $display("unexpected at %0t: no modulator update", $time);
         finish_test();
      end
   endtask : wait_update

   // Enter full power-down, leave it by clearing each kind of bit in turn
   task automatic t_full();
      for (int i = 0; i < 3; i++) begin
         i_apgc_host_model.host_write(1'b1, 2'h3, 1'b1, 1'b1, 3'h0, 3'h0);
         cyc(2);
         check(full_power_down_o, 24'h000001, "full entry");
         check({analog_enable_o, por_monitor_enable_o, internal_reference_enable_o}, 24'h0, "analog on");
         check({clock_distribution_enable_o, modulator_sample_clock_o}, 24'h0, "clock runs");
         check(input_sampling_clock_enable_o, 24'h0, "input clock runs");
         check(serial_interface_enable_o, 24'h000001, "serial gated");
         check(channel_enable_o, 24'h0, "channels on");
         i_apgc_host_model.host_write(1'b1, (i == 0) ? 2'h1 : 2'h3, i != 1, i != 2, 3'h0, 3'h0);
         cyc(2);
         check({full_power_down_o, por_monitor_enable_o}, 24'h000001, "exit monitors");
      end
      $display("full power-down test done");
   endtask : t_full

   // Same request in two-wire mode is refused
   task automatic t_two_wire();
      i_apgc_host_model.host_write(1'b0, 2'h0, 1'b0, 1'b0, 3'h0, 3'h0);
      cyc(4);
      i_apgc_host_model.host_write(1'b0, 2'h3, 1'b1, 1'b1, 3'h0, 3'h0);
      cyc(5);
      check(full_power_down_o, 24'h0, "two-wire full");
      i_apgc_host_model.host_write(1'b1, 2'h0, 1'b0, 1'b0, 3'h0, 3'h0);
      cyc(4);
      $display("two-wire test done");
   endtask : t_two_wire

   // Every gain code, channels set to opposite codes
   task automatic t_gain();
      logic [2:0] c;
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         i_apgc_host_model.host_write(1'b1, 2'h0, 1'b0, 1'b0, c, ~c);
         cyc(2);
         check(gain_ch0_o, gx(c), "gain ch0");
         check(gain_ch1_o, gx(~c), "gain ch1");
      end
      $display("gain test done");
   endtask : t_gain

   // Channel 0 alone down: its data flushed, channel 1 unaffected
   task automatic t_chan();
      i_apgc_host_model.host_write(1'b1, 2'h1, 1'b0, 1'b0, 3'h0, 3'h0);
      cyc(3);
      check(channel_enable_o, 24'h000002, "channel map");
      check(clock_distribution_enable_o, 24'h000001, "clock kept");
      conv_data_ch0_i = 24'hA5A5A5;
      conv_data_ch1_i = 24'h5A5A5A;
      conv_ready_i = 2'h3;
      cyc(1);
      conv_ready_i = 2'h0;
      check(data_ready_o, 24'h000002, "ready mask");
      check(data_ch0_o, 24'h000000, "data flush");
      check(data_ch1_o, 24'h5A5A5A, "data pass");
      $display("channel test done");
   endtask : t_chan

   // Update period and quantizer coding, one input with a bubble
   task automatic t_mod();
      int n;
      i_apgc_host_model.host_write(1'b1, 2'h0, 1'b0, 1'b0, 3'h0, 3'h0);
      wait_update(n);
      wait_update(n);
      check(24'(n), 24'h0000C8, "update period");
      check(quant_level_ch0_o, 24'h000002, "level ch0");
      check(quant_therm_ch0_o, 24'h000003, "therm ch0");
      check({quant_level_ch1_o, quant_therm_ch1_o}, 24'h00004F, "ch1 full scale");
      $display("modulator test done");
   endtask : t_mod

   // Main sequence
   initial begin
      repeat (2) @(posedge clock_i);
      @(negedge clock_i);
      rst_n_i = 1'b1;
      cyc(3);
      t_full();
      t_two_wire();
      t_gain();
      t_chan();
      t_mod();
      finish_test();
   end
endmodule : test_afe_power_gain_control
